//--- design/udt_desc_table.sv
// Purpose: descriptor table engine over the shared USB RAM
// Assumes: token, data and handshake strobes from the packet engine
// Notes:   RAM has no reset; core writes lose to engine writes
module udt_desc_table
  import udt_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] core_addr,
  input  wire logic       core_wr,
  input  wire logic [7:0] core_wdata,
  output logic      [7:0] core_rd_data,
  input  wire logic [7:0] ep_in_en,
  input  wire logic       tok_valid,
  input  wire logic [3:0] tok_pid,
  input  wire logic [2:0] tok_ep,
  input  wire logic [4:0] tok_bd,
  output logic            tok_ready,
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_byte,
  input  wire logic       rx_data1,
  input  wire logic       rx_end,
  input  wire logic       rx_err,
  input  wire logic       tx_ready,
  output logic            tx_valid,
  output logic      [7:0] tx_byte,
  output logic            tx_last,
  output logic            tx_data1,
  output logic            tx_zlp,
  input  wire logic       host_ack,
  input  wire logic       host_timeout,
  output logic            hs_valid,
  output logic      [1:0] hs_code,
  output logic            trn_done,
  output logic      [7:0] last_status,
  output logic      [7:0] ep_stall_set,
  output logic            stall_irq
);

  logic [7:0] ram [RAM_BYTES];
  udt_state_e state_q;
  logic [7:0] base_q;
  logic [2:0] ep_q;
  logic [3:0] pid_q;
  logic [7:0] stat_q;
  logic [9:0] cnt_q;
  logic [7:0] adr_q;
  logic [9:0] idx_q;
  logic       ovf_q;
  logic [7:0] tok_base;
  logic [7:0] tok_stat;
  logic       stall_hit;
  logic       tog_bad;
  logic       rx_wr;
  logic       rx_fin;
  logic       rx_ok;
  logic       tx_fin;
  logic       wb_en;
  logic [9:0] wb_cnt;
  logic [7:0] wb_stat;
  logic [9:0] idx_nx;
  logic [1:0] hs_d;
  logic       hs_d_v;
  logic       stall_d;

  // descriptor n sits at base plus 4n, 32 of them
  assign tok_base = TBL_BASE + {1'b0, tok_bd, 2'b00};
  assign tok_stat = ram[tok_base + OFS_STAT];

  // SETUP bypasses both the stall and the toggle check
  assign stall_hit = stat_q[STALL_BIT] && pid_q != PID_SETUP;
  assign tog_bad   = stat_q[CHK_BIT] && pid_q != PID_SETUP
                     && rx_data1 != stat_q[TOG_BIT];
  assign rx_wr     = state_q == ST_RX && rx_valid && stat_q[OWN_BIT]
                     && !stall_hit && !tog_bad && idx_q < cnt_q;
  assign rx_fin    = state_q == ST_RX && rx_end;
  assign rx_ok     = stat_q[OWN_BIT] && !stall_hit && !rx_err && !ovf_q;
  assign tx_fin    = state_q == ST_WAIT && host_ack;
  assign wb_en     = (rx_fin && rx_ok && !tog_bad) || tx_fin;
  assign wb_cnt    = (pid_q == PID_IN) ? cnt_q : idx_q;
  // ownership cleared, bit 6 kept, PID in 5:2, count high in 1:0
  assign wb_stat   = {1'b0, stat_q[TOG_BIT], pid_q, wb_cnt[9:8]};
  assign idx_nx    = idx_q + 10'h001;

  always_comb begin
    hs_d_v  = 1'b0;
    hs_d    = HS_ACK;
    stall_d = 1'b0;
    if (rx_fin) begin
      hs_d_v = 1'b1;
      if (!stat_q[OWN_BIT] || (!stall_hit && (rx_err || ovf_q))) begin
        hs_d = HS_NAK;
      end else if (stall_hit) begin
        hs_d    = HS_STALL;
        stall_d = 1'b1;
      end
    end else if (state_q == ST_IDLE && tok_valid && ep_in_en[tok_ep]
                 && tok_pid == PID_IN) begin
      if (!tok_stat[OWN_BIT]) begin
        hs_d_v = 1'b1;
        hs_d   = HS_NAK;
      end else if (tok_stat[STALL_BIT]) begin
        hs_d_v  = 1'b1;
        hs_d    = HS_STALL;
        stall_d = 1'b1;
      end
    end
  end

  // shared RAM; the core may read any byte at any time
  always_ff @(posedge clk) begin
    if (core_wr) begin
      ram[core_addr] <= core_wdata;
    end
    if (rx_wr) begin
      ram[adr_q + idx_q[7:0]] <= rx_byte;
    end
    if (wb_en) begin
      ram[base_q + OFS_CNT]  <= wb_cnt[7:0];
      ram[base_q + OFS_STAT] <= wb_stat;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      core_rd_data <= 8'h00;
    end else begin
      core_rd_data <= ram[core_addr];
    end
  end

  // transaction sequencer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q  <= ST_IDLE;
      base_q   <= 8'h00;
      ep_q     <= 3'h0;
      pid_q    <= 4'h0;
      stat_q   <= 8'h00;
      cnt_q    <= 10'h000;
      adr_q    <= 8'h00;
      idx_q    <= 10'h000;
      ovf_q    <= 1'b0;
      tx_valid <= 1'b0;
      tx_byte  <= 8'h00;
      tx_last  <= 1'b0;
      tx_data1 <= 1'b0;
      tx_zlp   <= 1'b0;
    end else begin
      tx_zlp <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          // disabled endpoint: table bytes are plain RAM, token dropped
          if (tok_valid && ep_in_en[tok_ep]) begin
            base_q <= tok_base;
            ep_q   <= tok_ep;
            pid_q  <= tok_pid;
            stat_q <= tok_stat;
            cnt_q  <= {tok_stat[1:0], ram[tok_base + OFS_CNT]};
            adr_q  <= ram[tok_base + OFS_ADRL];
            idx_q  <= 10'h000;
            ovf_q  <= 1'b0;
            if (tok_pid != PID_IN) begin
              state_q <= ST_RX;
            end else if (tok_stat[OWN_BIT] && !tok_stat[STALL_BIT]) begin
              tx_data1 <= tok_stat[TOG_BIT];
              if ({tok_stat[1:0], ram[tok_base + OFS_CNT]} == 10'h000) begin
                tx_zlp  <= 1'b1;
                state_q <= ST_WAIT;
              end else begin
                tx_valid <= 1'b1;
                tx_byte  <= ram[ram[tok_base + OFS_ADRL]];
                tx_last  <= {tok_stat[1:0], ram[tok_base + OFS_CNT]}
                            == 10'h001;
                state_q  <= ST_TX;
              end
            end
          end
        end
        ST_RX: begin
          if (rx_valid) begin
            // bytes past the count are dropped and flag an overflow
            if (idx_q >= cnt_q) begin
              ovf_q <= 1'b1;
            end else begin
              idx_q <= idx_nx;
            end
          end
          if (rx_end) begin
            state_q <= ST_IDLE;
          end
        end
        ST_TX: begin
          if (tx_ready) begin
            if (idx_nx == cnt_q) begin
              tx_valid <= 1'b0;
              tx_last  <= 1'b0;
              state_q  <= ST_WAIT;
            end else begin
              idx_q   <= idx_nx;
              tx_byte <= ram[adr_q + idx_nx[7:0]];
              tx_last <= idx_nx + 10'h001 == cnt_q;
            end
          end
        end
        ST_WAIT: begin
          // no ack keeps ownership so the same buffer is resent
          if (host_ack || host_timeout) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // handshake and event strobes, one cycle each, and last_status held between completions
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hs_valid     <= 1'b0;
      hs_code      <= HS_ACK;
      trn_done     <= 1'b0;
      last_status  <= 8'h00;
      ep_stall_set <= 8'h00;
      stall_irq    <= 1'b0;
    end else begin
      hs_valid     <= hs_d_v;
      hs_code      <= hs_d;
      trn_done     <= wb_en;
      stall_irq    <= stall_d;
      ep_stall_set <= 8'h00;
      if (stall_d) begin
        ep_stall_set[state_q == ST_IDLE ? tok_ep : ep_q] <= 1'b1;
      end
      if (wb_en) begin
        last_status <= {2'b00, ep_q, pid_q == PID_IN, 2'b00};
      end
    end
  end

  // conservative: may lag the return to idle by one cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tok_ready <= 1'b0;
    end else begin
      tok_ready <= state_q == ST_IDLE && !tok_valid;
    end
  end

  a_stall_irq: assert property (@(posedge clk) disable iff (!rst_n)
    hs_valid && hs_code == HS_STALL |-> stall_irq && ep_stall_set != 8'h00)
    else $error("stall without endpoint flag");
  a_stall_keep: assert property (@(posedge clk) disable iff (!rst_n)
    stall_d |-> !wb_en) else $error("stalled descriptor changed");
  a_done_ack: assert property (@(posedge clk) disable iff (!rst_n)
    rx_fin && wb_en |=> hs_valid && hs_code == HS_ACK && trn_done)
    else $error("completion without ack");
  a_tog_bad: assert property (@(posedge clk) disable iff (!rst_n)
    rx_fin && rx_ok && tog_bad |=> hs_code == HS_ACK && !trn_done)
    else $error("bad toggle not acked quietly");
  a_setup_ok: assert property (@(posedge clk) disable iff (!rst_n)
    rx_fin && pid_q == PID_SETUP && rx_ok |-> wb_en)
    else $error("setup refused");
  a_ovf_nak: assert property (@(posedge clk) disable iff (!rst_n)
    rx_fin && ovf_q && stat_q[OWN_BIT] && !stall_hit
    |=> hs_code == HS_NAK && !trn_done) else $error("oversize not nak");
  a_own_clear: assert property (@(posedge clk) disable iff (!rst_n)
    wb_en |=> ram[base_q][OWN_BIT] == 1'b0)
    else $error("ownership not returned");
  a_no_write: assert property (@(posedge clk) disable iff (!rst_n)
    rx_wr |-> !tog_bad && idx_q < cnt_q) else $error("bad data stored");
  a_disabled: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == ST_IDLE && tok_valid && !ep_in_en[tok_ep]
    |=> state_q == ST_IDLE && !hs_valid) else $error("disabled ep served");

  a_in_nak: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == ST_IDLE && tok_valid && ep_in_en[tok_ep]
    && tok_pid == PID_IN && !tok_stat[OWN_BIT]
    |=> hs_valid && hs_code == HS_NAK) else $error("in not nak");
  a_in_stall: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == ST_IDLE && tok_valid && ep_in_en[tok_ep]
    && tok_pid == PID_IN && tok_stat[OWN_BIT] && tok_stat[STALL_BIT]
    |=> hs_code == HS_STALL && stall_irq) else $error("in not stalled");
  a_stall_desc: assert property (@(posedge clk) disable iff (!rst_n)
    stall_d |=> ram[base_q][OWN_BIT] && ram[base_q][STALL_BIT])
    else $error("stalled descriptor touched");
  a_stall_hot: assert property (@(posedge clk) disable iff (!rst_n)
    stall_irq |-> $onehot(ep_stall_set)) else $error("stall flag not one");
  a_setup_stall: assert property (@(posedge clk) disable iff (!rst_n)
    rx_fin && pid_q == PID_SETUP && rx_ok && stat_q[STALL_BIT]
    |=> hs_code == HS_ACK && trn_done) else $error("setup kept stall");

  a_pid_field: assert property (@(posedge clk) disable iff (!rst_n)
    wb_en |=> ram[$past(base_q)][5:2] == $past(pid_q))
    else $error("pid not written");
  a_tog_kept: assert property (@(posedge clk) disable iff (!rst_n)
    wb_en |=> ram[$past(base_q)][TOG_BIT] == $past(stat_q[TOG_BIT]))
    else $error("bit 6 written");
  a_cnt_field: assert property (@(posedge clk) disable iff (!rst_n)
    wb_en |=> ram[$past(base_q) + OFS_CNT] == $past(wb_cnt[7:0]))
    else $error("count byte wrong");
  a_hi_bits: assert property (@(posedge clk) disable iff (!rst_n)
    wb_en |=> ram[$past(base_q)][1:0] == $past(wb_cnt[9:8]))
    else $error("count high bits wrong");
  a_tog_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    rx_fin && tog_bad |=> ram[$past(base_q)] == $past(stat_q))
    else $error("bad toggle updated status");
  a_ovf_cnt: assert property (@(posedge clk) disable iff (!rst_n)
    rx_fin && ovf_q |=> ram[$past(base_q) + OFS_CNT] == $past(cnt_q[7:0]))
    else $error("oversize changed count");
  a_ovf_drop: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == ST_RX && rx_valid && idx_q >= cnt_q |-> !rx_wr)
    else $error("byte past count stored");

  a_tx_hold: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == ST_TX && !tx_ready |=> tx_valid && $stable(tx_byte))
    else $error("in byte dropped");
  a_in_last: assert property (@(posedge clk) disable iff (!rst_n)
    tx_valid && tx_last |-> idx_q + 10'h001 == cnt_q)
    else $error("last byte misplaced");
  a_zlp_cnt: assert property (@(posedge clk) disable iff (!rst_n)
    tx_zlp |-> state_q == ST_WAIT && cnt_q == 10'h000)
    else $error("zero length with count");
  a_timeout_own: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == ST_WAIT && host_timeout && !host_ack |=> !trn_done)
    else $error("timeout completed");
  a_done_status: assert property (@(posedge clk) disable iff (!rst_n)
    trn_done |-> last_status ==
    {2'b00, $past(ep_q), $past(pid_q == PID_IN), 2'b00})
    else $error("last status wrong");
  a_reset_idle: assert property (@(posedge clk)
    !rst_n |=> state_q == ST_IDLE && !hs_valid && !tx_valid && !trn_done)
    else $error("busy after reset");

  c_out_done: cover property (@(posedge clk) rx_fin && wb_en);
  c_in_done: cover property (@(posedge clk) tx_fin);
  c_stall: cover property (@(posedge clk) stall_d);
  c_tog_bad: cover property (@(posedge clk) rx_fin && rx_ok && tog_bad);
  c_in_zlp: cover property (@(posedge clk) tx_zlp);

endmodule : udt_desc_table

//--- design/udt_pkg.sv
// Purpose: constants for the endpoint buffer descriptor table logic
// Assumes: 256-byte dual-access USB RAM, descriptor table at its base
// Notes:   one clock; RAM offsets are 8-bit indexes into the USB RAM
//
// How it works
// - 32 descriptors, each controls one buffer
// - four bytes: status, count, addr low, high
// - table spans 8 to 128 bytes
// - descriptor live only if endpoint input enabled
// - status bit 7 set means engine owns
// - status readable by both sides always
// - engine writes token PID and count back
// - completion clears ownership flag
// - bit 3 enables toggle check against bit 6
// - bad toggle: ACK, no write, no update
// - no checking: good OUT acked and completed
// - SETUP accepted despite toggle mismatch
// - expected toggle ignored unless checking on
// - bit 2 stalls tokens, descriptor untouched
// - stall sets endpoint flag and interrupt
// - SETUP ignores stall, returns to core
// - 10-bit count, high bits in status
// - engine writes PID to 5:2, keeps 6
// - oversize OUT gets NAK, count unchanged
package udt_pkg;
  localparam int        BD_NUM        = 32;
  localparam int        TBL_MIN_BYTES = 8;
  localparam int        TBL_MAX_BYTES = 128;
  localparam int        RAM_BYTES     = 256;
  localparam logic [7:0] TBL_BASE     = 8'h00;
  localparam logic [7:0] RAM_HI_PAGE  = 8'h02;
  localparam logic [7:0] OFS_STAT     = 8'h00;
  localparam logic [7:0] OFS_CNT      = 8'h01;
  localparam logic [7:0] OFS_ADRL     = 8'h02;
  localparam logic [7:0] OFS_ADRH     = 8'h03;
  localparam int        OWN_BIT       = 7;
  localparam int        TOG_BIT       = 6;
  localparam int        CHK_BIT       = 3;
  localparam int        STALL_BIT     = 2;
  localparam logic [3:0] PID_OUT      = 4'h1;
  localparam logic [3:0] PID_IN       = 4'h9;
  localparam logic [3:0] PID_SETUP    = 4'hD;
  localparam logic [1:0] HS_ACK       = 2'h0;
  localparam logic [1:0] HS_NAK       = 2'h1;
  localparam logic [1:0] HS_STALL     = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX   = 3'b001,
    ST_TX   = 3'b010,
    ST_WAIT = 3'b011
  } udt_state_e;
endpackage : udt_pkg

//--- sim/udt_host_model.sv
// Purpose: host side model sending tokens, OUT data and IN acks
// Assumes: tasks are entered at a falling edge and return at one
// Notes:   idle PID and data lines show the inverted last value; endpoint and descriptor lines hold
module udt_host_model (
  input  wire logic       clk,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte,
  output logic            tok_valid,
  output logic      [3:0] tok_pid,
  output logic      [2:0] tok_ep,
  output logic      [4:0] tok_bd,
  output logic            rx_valid,
  output logic      [7:0] rx_byte,
  output logic            rx_data1,
  output logic            rx_end,
  output logic            rx_err,
  output logic            tx_ready,
  output logic            host_ack,
  output logic            host_timeout
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {tok_valid, rx_valid, rx_end, rx_err, tx_ready, host_ack} = '0;
    {tok_pid, tok_ep, tok_bd, rx_byte, rx_data1, host_timeout} = '0;
  end
  task automatic token(input logic [3:0] p, input logic [2:0] e,
                       input logic [4:0] b);
    tok_valid = 1'b1;
    {tok_pid, tok_ep, tok_bd} = {p, e, b};
    @(negedge clk);
    tok_valid = 1'b0;
    tok_pid = ~p;
  endtask : token
  task automatic send_out(input logic [3:0] p, input logic [2:0] e,
                          input logic [4:0] b, input int n,
                          input logic d1, input logic err);
    token(p, e, b);
    rx_data1 = d1;
    for (int i = 0; i < n; i++) begin
      rx_valid = 1'b1;
      rx_byte = 8'hA0 + 8'(i);
      @(negedge clk);
    end
    rx_valid = 1'b0;
    rx_byte = ~rx_byte;
    {rx_end, rx_err} = {1'b1, err};
    @(negedge clk);
    {rx_end, rx_err, rx_data1} = {2'b00, ~d1};
  endtask : send_out
  task automatic take_in(output logic [7:0] d);
    int n;
    n = 0;
    // slow sink: the byte has to stand while we stall
    repeat (2) @(negedge clk);
    while (tx_valid !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    d = tx_byte;
    tx_ready = 1'b1;
    @(negedge clk);
    tx_ready = 1'b0;
    @(negedge clk);
    host_ack = 1'b1;
    @(negedge clk);
    host_ack = 1'b0;
  endtask : take_in
  task automatic end_in(input logic to);
    {host_ack, host_timeout} = {~to, to};
    @(negedge clk);
    {host_ack, host_timeout} = 2'b00;
  endtask : end_in
endmodule : udt_host_model

//--- sim/tb_top.sv
// Purpose: self-checking bench for the descriptor table engine
// Assumes: firmware side driven here, host side by the model
// Notes:   only endpoints 0 to 2 enabled; endpoint 3 stays dead
module tb_top;
  import udt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, rst_n, core_wr, tok_valid, tok_ready, rx_valid;
  logic       rx_data1, rx_end, rx_err, tx_ready, tx_valid, tx_last;
  logic       tx_data1, tx_zlp, host_ack, host_timeout, hs_valid;
  logic       trn_done, stall_irq;
  logic [7:0] core_addr, core_wdata, core_rd_data, ep_in_en, rx_byte;
  logic [7:0] tx_byte, last_status, ep_stall_set, stall_or, rd_b;
  logic [3:0] tok_pid;
  logic [2:0] tok_ep;
  logic [4:0] tok_bd;
  logic [1:0] hs_code, hs_got, tx_flags;
  int         fail_count, num_checks, hs_n, done_n, irq_n, cyc, zlp_n;
  udt_desc_table dut_u (.clk, .rst_n, .core_addr, .core_wr, .core_wdata,
    .core_rd_data, .ep_in_en, .tok_valid, .tok_pid, .tok_ep, .tok_bd,
    .tok_ready, .rx_valid, .rx_byte, .rx_data1, .rx_end, .rx_err,
    .tx_ready, .tx_valid, .tx_byte, .tx_last, .tx_data1, .tx_zlp,
    .host_ack, .host_timeout, .hs_valid, .hs_code, .trn_done,
    .last_status, .ep_stall_set, .stall_irq);
  udt_host_model host_u (.clk, .tx_valid, .tx_byte, .tok_valid, .tok_pid,
    .tok_ep, .tok_bd, .rx_valid, .rx_byte, .rx_data1, .rx_end, .rx_err,
    .tx_ready, .host_ack, .host_timeout);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // pulses are one cycle wide, so tally them rather than poll
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (hs_valid === 1'b1) begin
      hs_n <= hs_n + 1;
      hs_got <= hs_code;
    end
    if (trn_done === 1'b1) done_n <= done_n + 1;
    if (stall_irq === 1'b1) irq_n <= irq_n + 1;
    if (tx_zlp === 1'b1) zlp_n <= zlp_n + 1;
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      tx_flags <= {tx_last, tx_data1};
    end
    stall_or <= stall_or | ep_stall_set;
    if (cyc == 3000) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [7:0] g, input logic [7:0] e,
                     input string m);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    {core_addr, core_wdata, core_wr} = {a, d, 1'b1};
    @(negedge clk);
    core_wr = 1'b0;
    @(negedge clk);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    core_addr = a;
    @(negedge clk);
    chk(core_rd_data, e, "ram read");
  endtask : rdc
  // status byte goes last so the engine never sees a half-built entry
  task automatic arm(input logic [4:0] b, input logic [7:0] cnt,
                     input logic [7:0] adr, input logic [7:0] st);
    wr({1'b0, b, 2'b01}, cnt);
    wr({1'b0, b, 2'b10}, adr);
    wr({1'b0, b, 2'b11}, 8'h00);
    wr({1'b0, b, 2'b00}, st);
  endtask : arm
  task automatic clr();
    {hs_n, done_n, irq_n, zlp_n, stall_or} = '0;
  endtask : clr
  task automatic outcome(input int h, input logic [1:0] c, input int d);
    repeat (3) @(negedge clk);
    chk(8'(hs_n), 8'(h), "handshakes");
    if (h > 0) chk({6'h00, hs_got}, {6'h00, c}, "handshake code");
    chk(8'(done_n), 8'(d), "completions");
  endtask : outcome
  task automatic run_out(input logic [3:0] p, input logic [2:0] e,
                         input logic [4:0] b, input int n, input logic d1,
                         input logic err, input logic [1:0] c, input int d);
    clr();
    host_u.send_out(p, e, b, n, d1, err);
    outcome(1, c, d);
  endtask : run_out
  initial begin
    {rst_n, core_wr, core_addr, core_wdata} = '0;
    ep_in_en = 8'h00;
    clr();
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    arm(5'd0, 8'h02, 8'h40, 8'h81);
    ep_in_en = 8'h07;
    chk({7'h00, tok_ready}, 8'h01, "token ready");
    run_out(PID_OUT, 3'd0, 5'd0, 2, 1'b0, 1'b0, HS_ACK, 1);
    rdc(8'h00, 8'h04);
    rdc(8'h01, 8'h02);
    rdc(8'h40, 8'hA0);
    rdc(8'h41, 8'hA1);
    wr(8'h50, 8'h11);
    arm(5'd1, 8'h04, 8'h50, 8'hC8);
    run_out(PID_OUT, 3'd0, 5'd1, 1, 1'b0, 1'b0, HS_ACK, 0);
    rdc(8'h04, 8'hC8);
    rdc(8'h50, 8'h11);
    run_out(PID_OUT, 3'd0, 5'd1, 1, 1'b1, 1'b0, HS_ACK, 1);
    rdc(8'h04, 8'h44);
    rdc(8'h50, 8'hA0);
    arm(5'd1, 8'h04, 8'h50, 8'h88);
    run_out(PID_SETUP, 3'd0, 5'd1, 1, 1'b1, 1'b0, HS_ACK, 1);
    rdc(8'h04, 8'h34);
    arm(5'd2, 8'h00, 8'h58, 8'h84);
    clr();
    host_u.token(PID_IN, 3'd1, 5'd2);
    outcome(1, HS_STALL, 0);
    chk(stall_or, 8'h02, "endpoint stall");
    chk(8'(irq_n), 8'h01, "stall interrupt");
    rdc(8'h08, 8'h84);
    run_out(PID_SETUP, 3'd1, 5'd2, 0, 1'b0, 1'b0, HS_ACK, 1);
    rdc(8'h08, 8'h34);
    chk(last_status, 8'h08, "last status out");
    arm(5'd0, 8'h01, 8'h40, 8'h80);
    run_out(PID_OUT, 3'd0, 5'd0, 2, 1'b0, 1'b0, HS_NAK, 0);
    run_out(PID_OUT, 3'd0, 5'd0, 1, 1'b0, 1'b1, HS_NAK, 0);
    rdc(8'h00, 8'h80);
    rdc(8'h01, 8'h01);
    arm(5'd3, 8'h04, 8'h60, 8'h00);
    run_out(PID_OUT, 3'd1, 5'd3, 1, 1'b0, 1'b0, HS_NAK, 0);
    clr();
    host_u.token(PID_IN, 3'd3, 5'd6);
    outcome(0, HS_ACK, 0);
    wr(8'h68, 8'h5A);
    arm(5'd31, 8'h01, 8'h68, 8'hC0);
    clr();
    host_u.token(PID_IN, 3'd2, 5'd31);
    host_u.take_in(rd_b);
    chk(rd_b, 8'h5A, "in data");
    outcome(0, HS_ACK, 1);
    chk({6'h00, tx_flags}, 8'h03, "in last and toggle");
    chk(last_status, 8'h14, "last status in");
    rdc(8'h7C, 8'h64);
    rdc(8'h7D, 8'h01);
    arm(5'd5, 8'h00, 8'h58, 8'h80);
    clr();
    host_u.token(PID_IN, 3'd2, 5'd5);
    host_u.end_in(1'b1);
    outcome(0, HS_ACK, 0);
    chk(8'(zlp_n), 8'h01, "zero length");
    rdc(8'h14, 8'h80);
    clr();
    host_u.token(PID_IN, 3'd2, 5'd5);
    host_u.end_in(1'b0);
    outcome(0, HS_ACK, 1);
    chk(8'(zlp_n), 8'h01, "zero length again");
    rdc(8'h14, 8'h24);
    rdc(8'h15, 8'h00);
    wrap_up();
  end
endmodule : tb_top
